// File: src/cmpsi_pkg.sv
/*
 * Shared constants for the compass two-wire slave port: addresses,
 * command codes, non-volatile locations, mode and orientation encodings.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cmpsi_pkg;
    // Factory slave address byte, write form (bit 0 cleared)
    localparam logic [7:0] CMPSI_ADDR_DEFAULT = 8'h32;
    // Non-volatile locations
    localparam logic [7:0] CMPSI_NV_ADDR = 8'h00;
    localparam logic [7:0] CMPSI_NV_OPMODE = 8'h04;
    // Orientation commands
    localparam logic [7:0] CMPSI_CMD_LEVEL = 8'h72;
    localparam logic [7:0] CMPSI_CMD_EDGE = 8'h73;
    localparam logic [7:0] CMPSI_CMD_FRONT = 8'h74;
    // Mode commands (run, standby, sleep)
    localparam logic [7:0] CMPSI_CMD_RUN = 8'h75;
    localparam logic [7:0] CMPSI_CMD_STANDBY = 8'h76;
    localparam logic [7:0] CMPSI_CMD_SLEEP = 8'h83;
    // Reset command reloads non-volatile settings
    localparam logic [7:0] CMPSI_CMD_RESET = 8'h82;
    // Operating mode byte: orientation bits and run bit
    localparam int CMPSI_OPM_LEVEL_BIT = 0;
    localparam int CMPSI_OPM_EDGE_BIT = 1;
    localparam int CMPSI_OPM_FRONT_BIT = 2;
    localparam int CMPSI_OPM_RUN_BIT = 4;
    localparam logic [7:0] CMPSI_OPMODE_DEFAULT = 8'h11;
    // Bus rate and link clock limits
    localparam int CMPSI_CLK_HZ = 40000000;
    localparam int CMPSI_BIT_RATE = 100000;
    localparam int CMPSI_BIT_CYCLES = CMPSI_CLK_HZ / CMPSI_BIT_RATE;
    // Operating modes
    typedef enum logic [2:0] {
        CMPSI_SLEEP = 3'h1,
        CMPSI_STANDBY = 3'h2,
        CMPSI_RUN = 3'h4
    } cmpsi_mode_t;
    // Mounting orientations
    typedef enum logic [2:0] {
        CMPSI_LEVEL = 3'h1,
        CMPSI_EDGE = 3'h2,
        CMPSI_FRONT = 3'h4
    } cmpsi_orient_t;
    // Serial engine states
    typedef enum logic [5:0] {
        CMPSI_IDLE = 6'h01,
        CMPSI_ADDR = 6'h02,
        CMPSI_AACK = 6'h04,
        CMPSI_WDATA = 6'h08,
        CMPSI_RDATA = 6'h10,
        CMPSI_RACK = 6'h20
    } cmpsi_state_t;
endpackage : cmpsi_pkg

// File: src/cmpsi_slave.sv
/*
 * Compass two-wire slave port with mode and orientation control.
 * Assumes scl and sda arrive asynchronously from the pins, pull-ups
 * outside, and a non-volatile store that presents its slave address
 * and operating mode bytes as stable levels.
 */
// Function
// - Three modes; sleep switches analog circuitry off.
// - Standby: powered, no measuring, waits for commands.
// - Run: measures continuously and still takes commands.
// - Persistent mode kept in non-volatile location 0x04.
// - Level is the default; two upright orientations exist.
// - Commands 0x72, 0x73, 0x74 select level, edge, front.
// - Orientation in byte 0x04 takes effect after reset only.
// - Slave only, standard-mode 100 kbit/s.
// - Each unit is eight bits then one acknowledge slot.
// - Data returned is binary, two's complement.
// - Factory address byte 0x32 write, 0x33 read.
// - Receiver pulls sda low to acknowledge, high to refuse.
// - Data changes only while scl is low.
// - Sda falling with scl high is start; rising is stop.
// - Repeated start begins a new transaction; here it restarts the address phase but wcnt clears only at stop.
// - Address byte: bits 7 to 1 address, bit 0 read.
// - Write sends data bytes; read shifts device bytes out.
// - Write carries command then up to two argument bytes.
// - Read bytes depend on the last written command.
// - New slave address applies after reset only.
`timescale 1ns/1ps
module cmpsi_slave
    import cmpsi_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Two-wire pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Non-volatile settings, sampled at reset release or reset command
    input wire logic [7:0] nv_slave_addr,
    input wire logic [7:0] nv_opmode,
    // Response data source, one byte per index
    input wire logic [7:0] resp_byte,
    output logic [2:0] resp_index,
    // Device state
    output logic [7:0] last_cmd,
    output logic [15:0] cmd_arg,
    output logic cmd_valid,
    output logic analog_on,
    output logic measure_en,
    output logic upright_edge_orientation,
    output logic upright_front_orientation
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and condition detect
    logic [1:0] scl_s, sda_s;
    logic scl_d, sda_d;
    logic scl_rise, scl_fall, start_c, stop_c;

    // Two synchroniser flops then one delay flop per pin; the first is read only by the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce) begin
            scl_s <= {scl_s[0], scl_in};
            sda_s <= {sda_s[0], sda_in};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end

    // Edges found by the system clock, far faster than 100 kbit/s
    always_comb begin
        scl_rise = scl_s[1] & ~scl_d;
        scl_fall = ~scl_s[1] & scl_d;
        start_c = scl_s[1] & scl_d & sda_d & ~sda_s[1];
        stop_c = scl_s[1] & scl_d & ~sda_d & sda_s[1];
    end

    ////////////////////////////////////////////////////////////////////
    // Settings loaded at reset: address, mode, orientation
    logic loaded, reload;
    logic [6:0] my_addr, next_my_addr;
    cmpsi_mode_t mode, next_mode;
    cmpsi_orient_t orient, next_orient;
    logic [2:0] opm_orient;

    always_comb begin
        opm_orient = {nv_opmode[CMPSI_OPM_FRONT_BIT],
                      nv_opmode[CMPSI_OPM_EDGE_BIT],
                      nv_opmode[CMPSI_OPM_LEVEL_BIT]};
    end

    // State machine defined below; serial engine signals used here
    cmpsi_state_t state, next_state;
    logic [7:0] shreg, next_shreg;
    logic [3:0] bitcnt, next_bitcnt;
    logic [1:0] wcnt, next_wcnt;
    logic byte_done;
    logic [7:0] rx_byte;

    // Non-volatile values take effect only here, never live
    always_comb begin
        next_my_addr = my_addr;
        next_mode = mode;
        next_orient = orient;
        if (!loaded || reload) begin
            next_my_addr = nv_slave_addr[7:1];
            next_mode = nv_opmode[CMPSI_OPM_RUN_BIT] ? CMPSI_RUN
                : CMPSI_STANDBY;
            unique case (opm_orient)
                3'h2: next_orient = CMPSI_EDGE;
                3'h4: next_orient = CMPSI_FRONT;
                default: next_orient = CMPSI_LEVEL;
            endcase
        end else if (byte_done && state == CMPSI_WDATA && wcnt == 2'h0) begin
            unique case (rx_byte)
                CMPSI_CMD_LEVEL: next_orient = CMPSI_LEVEL;
                CMPSI_CMD_EDGE: next_orient = CMPSI_EDGE;
                CMPSI_CMD_FRONT: next_orient = CMPSI_FRONT;
                CMPSI_CMD_RUN: next_mode = CMPSI_RUN;
                CMPSI_CMD_STANDBY: next_mode = CMPSI_STANDBY;
                CMPSI_CMD_SLEEP: next_mode = CMPSI_SLEEP;
                default: ;
            endcase
        end
    end

    // Factory values until the first clocked load after release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            loaded <= 1'b0;
            my_addr <= CMPSI_ADDR_DEFAULT[7:1];
            mode <= CMPSI_RUN;
            orient <= CMPSI_LEVEL;
        end else if (ce) begin
            loaded <= 1'b1;
            my_addr <= next_my_addr;
            mode <= next_mode;
            orient <= next_orient;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial engine
    logic rw, next_rw;
    logic sda_drv, next_sda_drv;
    logic [7:0] next_last_cmd;
    logic [15:0] next_cmd_arg;
    logic next_cmd_valid;
    logic [2:0] next_resp_index;
    logic next_reload;

    always_comb begin
        rx_byte = {shreg[6:0], sda_s[1]};
        byte_done = scl_rise && bitcnt == 4'h7;
    end

    // Bits sampled on scl rise, sda changed on scl fall
    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_wcnt = wcnt;
        next_rw = rw;
        next_sda_drv = sda_drv;
        next_last_cmd = last_cmd;
        next_cmd_arg = cmd_arg;
        next_cmd_valid = 1'b0;
        next_resp_index = resp_index;
        next_reload = 1'b0;
        if (start_c) begin
            next_state = CMPSI_ADDR;
            next_bitcnt = 4'h0;
            next_sda_drv = 1'b0;
        end else if (stop_c) begin
            next_state = CMPSI_IDLE;
            next_sda_drv = 1'b0;
            if (wcnt != 2'h0) begin
                next_cmd_valid = 1'b1;
                next_reload = last_cmd == CMPSI_CMD_RESET;
            end
            next_wcnt = 2'h0;
        end else begin
            unique case (state)
                CMPSI_IDLE: ;
                CMPSI_ADDR, CMPSI_WDATA: begin
                    if (scl_rise) begin
                        next_shreg = rx_byte;
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    if (byte_done && state == CMPSI_ADDR) begin
                        next_rw = sda_s[1];
                        if (rx_byte[7:1] == my_addr) begin
                            next_state = CMPSI_AACK;
                        end else begin
                            next_state = CMPSI_IDLE;
                        end
                    end else if (byte_done) begin
                        // A fourth byte is refused and the rest ignored
                        next_state = (wcnt == 2'h3) ? CMPSI_IDLE
                            : CMPSI_AACK;
                        if (wcnt == 2'h0) begin
                            next_last_cmd = rx_byte;
                            next_resp_index = 3'h0;
                        end else if (wcnt == 2'h1) begin
                            next_cmd_arg = {rx_byte, 8'h00};
                        end else if (wcnt == 2'h2) begin
                            next_cmd_arg = {cmd_arg[15:8], rx_byte};
                        end
                        if (wcnt != 2'h3) begin
                            next_wcnt = wcnt + 2'h1;
                        end
                    end
                end
                CMPSI_AACK: begin
                    // Ack low through the ninth clock
                    if (scl_fall && !sda_drv) begin
                        next_sda_drv = 1'b1;
                    end else if (scl_fall) begin
                        next_bitcnt = 4'h0;
                        if (rw) begin
                            next_state = CMPSI_RDATA;
                            next_shreg = resp_byte;
                            next_sda_drv = ~resp_byte[7];
                            next_resp_index = resp_index + 3'h1;
                        end else begin
                            next_state = CMPSI_WDATA;
                            next_sda_drv = 1'b0;
                        end
                    end
                end
                CMPSI_RDATA: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h7) begin
                            next_state = CMPSI_RACK;
                            next_sda_drv = 1'b0; // Master's ack slot
                        end else begin
                            next_bitcnt = bitcnt + 4'h1;
                            next_shreg = {shreg[6:0], 1'b0};
                            next_sda_drv = ~shreg[6];
                        end
                    end else if (scl_rise && bitcnt == 4'h7) begin
                        next_bitcnt = 4'h7;
                    end
                end
                CMPSI_RACK: begin
                    // Master refusal ends the read; ack loads next byte
                    if (scl_rise && sda_s[1]) begin
                        next_state = CMPSI_IDLE;
                        next_sda_drv = 1'b0;
                    end else if (scl_fall) begin
                        next_state = CMPSI_RDATA;
                        next_bitcnt = 4'h0;
                        next_shreg = resp_byte;
                        next_sda_drv = ~resp_byte[7];
                        next_resp_index = resp_index + 3'h1;
                    end
                end
                default: next_state = CMPSI_IDLE;
            endcase
        end
    end

    // Slave only: never drives scl, only pulls sda low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= CMPSI_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            wcnt <= 2'h0;
            rw <= 1'b0;
            sda_drv <= 1'b0;
            last_cmd <= 8'h00;
            cmd_arg <= 16'h0000;
            cmd_valid <= 1'b0;
            resp_index <= 3'h0;
            reload <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            wcnt <= next_wcnt;
            rw <= next_rw;
            sda_drv <= next_sda_drv;
            last_cmd <= next_last_cmd;
            cmd_arg <= next_cmd_arg;
            cmd_valid <= next_cmd_valid;
            resp_index <= next_resp_index;
            reload <= next_reload;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
            analog_on <= 1'b0;
            measure_en <= 1'b0;
            upright_edge_orientation <= 1'b0;
            upright_front_orientation <= 1'b0;
        end else if (ce) begin
            sda_out <= 1'b0;
            sda_oe <= next_sda_drv;
            analog_on <= next_mode != CMPSI_SLEEP;
            measure_en <= next_mode == CMPSI_RUN;
            upright_edge_orientation <= next_orient == CMPSI_EDGE;
            upright_front_orientation <= next_orient == CMPSI_FRONT;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    miss_no_ack_a: assert property (ce && state == CMPSI_ADDR && byte_done
        && rx_byte[7:1] != my_addr |=> ##1 !sda_oe [*3])
        else $error("ack driven for foreign address");
    sleep_analog_a: assert property (loaded && mode == CMPSI_SLEEP
        |-> !analog_on)
        else $error("analog on in sleep");
    standby_idle_a: assert property (loaded && mode == CMPSI_STANDBY
        |-> analog_on && !measure_en)
        else $error("standby state wrong");
    run_measure_a: assert property (loaded && mode == CMPSI_RUN
        |-> measure_en)
        else $error("run not measuring");
    orient_cmd_a: assert property (ce && byte_done && state == CMPSI_WDATA
        && wcnt == 2'h0 && rx_byte == CMPSI_CMD_EDGE && loaded && !reload
        |=> ##1 upright_edge_orientation)
        else $error("edge command ignored");
    nv_hold_a: assert property (ce && loaded && !reload && $changed(nv_opmode)
        && !byte_done |=> $stable(orient))
        else $error("orientation followed store live");
    sda_scl_low_a: assert property (ce && state == CMPSI_RDATA
        && scl_s[1] && scl_d |=> $stable(sda_oe))
        else $error("sda changed while scl high");
    start_new_a: assert property (ce && start_c |=> state == CMPSI_ADDR)
        else $error("start not restarting");
    stop_idle_a: assert property (ce && stop_c |=> state == CMPSI_IDLE
        && !sda_drv)
        else $error("stop not releasing");

    cmd_cov_c: cover property (cmd_valid);
    read_cov_c: cover property (state == CMPSI_RDATA);
    miss_cov_c: cover property (state == CMPSI_ADDR ##1 state == CMPSI_IDLE);
    edge_cov_c: cover property (upright_edge_orientation);

endmodule : cmpsi_slave

// File: testbench/cmpsi_master_model.sv
/*
 * Behavioural two-wire bus master that drives the compass slave port.
 * Assumes an open-drain wire with a pull-up, resolved by the bench, and
 * tasks called from the bench while the model's clock runs.
 */
`timescale 1ns/1ps
module cmpsi_master_model
    import cmpsi_pkg::*;
#(
    parameter int HALF = 10
)(
    // Clock
    input wire logic clk,
    // Resolved data wire level
    input wire logic sda_in,
    // Open-drain controls, high means released
    output logic scl_rel,
    output logic sda_rel
);
    ////////////////////////////////////////////////////////////////////////
    // Both lines released at power-up so the pull-ups define idle
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end

    // Waits whole clock cycles; all line changes land on falling edges
    task automatic wait_q(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_q

    // One clock pulse; data moves only while scl is low
    // Each step is HALF/2 cycles, five by default, so the synchroniser keeps up
    task automatic clock_bit(input logic b, output logic s);
        wait_q(HALF / 2);
        sda_rel = b;
        wait_q(HALF / 2);
        scl_rel = 1'b1;
        wait_q(HALF / 2);
        s = sda_in;
        wait_q(HALF / 2);
        scl_rel = 1'b0;
    endtask : clock_bit

    ////////////////////////////////////////////////////////////////////////
    // Start, also used as repeated start after a write byte
    task automatic start_cond();
        sda_rel = 1'b1;
        wait_q(HALF / 2);
        scl_rel = 1'b1;
        wait_q(HALF / 2);
        sda_rel = 1'b0;
        wait_q(HALF / 2);
        scl_rel = 1'b0;
    endtask : start_cond

    // Stop closes every transaction
    task automatic stop_cond();
        wait_q(HALF / 2);
        sda_rel = 1'b0;
        wait_q(HALF / 2);
        scl_rel = 1'b1;
        wait_q(HALF / 2);
        sda_rel = 1'b1;
        wait_q(HALF);
    endtask : stop_cond

    // Eight bits MSB first, then a ninth pulse with sda released
    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, ack);
    endtask : write_byte

    // Reads eight bits, then acknowledges low or refuses high
    task automatic read_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, b[i]);
        end
        clock_bit(ack, s);
    endtask : read_byte
endmodule : cmpsi_master_model

// File: testbench/tb_cmpsi_slave.sv
/*
 * Self-checking bench for the compass slave port: orientation, modes,
 * arguments, address refusal, reads and non-volatile reload.
 * Assumes the master model above and a pull-up on the data wire.
 */
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    bad_count++; $display("BAD %0t %h vs %h", $time, got, exp); end end
module tb_cmpsi_slave
    import cmpsi_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] nv_addr = 8'h32;
    logic [7:0] nv_opm = 8'h11;
    logic scl_rel, sda_rel, sda_out, sda_oe, cmd_valid, analog_on;
    logic measure_en, edge_o, front_o, prev_scl, prev_oe;
    logic [2:0] resp_index;
    logic [7:0] last_cmd, rb;
    logic [15:0] cmd_arg;
    logic [4:0] acks;
    int bad_count = 0;
    int comparisons = 0;
    int cv_count = 0;
    // Wire-and of both parties; released means pulled high
    wire sda_w = sda_rel & ~(sda_oe & ~sda_out);
    // Response source: recognisable byte per index
    wire [7:0] resp_byte = 8'hA0 | {5'h00, resp_index};

    ////////////////////////////////////////////////////////////////////////
    cmpsi_master_model #(.HALF(10)) cmpsi_master_model_i (.clk(clk),
        .sda_in(sda_w), .scl_rel(scl_rel), .sda_rel(sda_rel));
    cmpsi_slave cmpsi_slave_i (.clk(clk), .rstn(rstn), .ce(1'b1),
        .scl_in(scl_rel), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .nv_slave_addr(nv_addr), .nv_opmode(nv_opm),
        .resp_byte(resp_byte), .resp_index(resp_index),
        .last_cmd(last_cmd), .cmd_arg(cmd_arg), .cmd_valid(cmd_valid),
        .analog_on(analog_on), .measure_en(measure_en),
        .upright_edge_orientation(edge_o),
        .upright_front_orientation(front_o));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Watches the wire: device may only move sda while scl stays low
    always @(posedge clk) begin
        prev_scl <= scl_rel;
        prev_oe <= sda_oe;
        if (prev_scl === 1'b1 && scl_rel === 1'b1 && rstn === 1'b1) begin
            `CHECK(sda_oe, prev_oe)
        end
        if (cmd_valid === 1'b1) begin
            cv_count++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Whole write transaction of n bytes, acknowledge bits returned
    task automatic send(input logic [7:0] b [5], input int n);
        acks = 5'h1F;
        cmpsi_master_model_i.start_cond();
        for (int i = 0; i < n; i++) begin
            cmpsi_master_model_i.write_byte(b[i], acks[i]);
        end
        cmpsi_master_model_i.stop_cond();
    endtask : send

    task automatic t_orient();
        logic [7:0] cmd [3] = '{8'h73, 8'h74, 8'h72};
        logic [1:0] exp [3] = '{2'b10, 2'b01, 2'b00};
        for (int i = 0; i < 3; i++) begin
            send('{8'h32, cmd[i], 8'h00, 8'h00, 8'h00}, 2);
            `CHECK(acks[1:0], 2'b00)
            `CHECK({edge_o, front_o}, exp[i])
        end
    endtask : t_orient

    // Sleep, standby and run in turn
    task automatic t_modes();
        logic [7:0] cmd [3] = '{8'h83, 8'h76, 8'h75};
        logic [1:0] exp [3] = '{2'b00, 2'b10, 2'b11};
        for (int i = 0; i < 3; i++) begin
            send('{8'h32, cmd[i], 8'h00, 8'h00, 8'h00}, 2);
            `CHECK({analog_on, measure_en}, exp[i])
        end
    endtask : t_modes

    // A fourth data byte overruns the command and must be refused
    task automatic t_args();
        int cv0;
        cv0 = cv_count;
        send('{8'h32, 8'h40, 8'h12, 8'h34, 8'h56}, 5);
        `CHECK(acks, 5'b10000)
        `CHECK(cmd_arg, 16'h1234)
        `CHECK(last_cmd, 8'h40)
        `CHECK(cv_count, cv0 + 1)
    endtask : t_args

    // Foreign address: nothing acknowledged, state untouched
    task automatic t_nack_addr();
        send('{8'h34, 8'h73, 8'h00, 8'h00, 8'h00}, 2);
        `CHECK(acks[1:0], 2'b11)
        `CHECK(edge_o, 1'b0)
    endtask : t_nack_addr

    // Read after write, then again through a repeated start
    task automatic t_read();
        logic a;
        send('{8'h32, 8'h45, 8'h00, 8'h00, 8'h00}, 2);
        cmpsi_master_model_i.start_cond();
        cmpsi_master_model_i.write_byte(8'h33, a);
        `CHECK(a, 1'b0)
        cmpsi_master_model_i.read_byte(1'b0, rb);
        `CHECK(rb, 8'hA0)
        cmpsi_master_model_i.read_byte(1'b1, rb);
        `CHECK(rb, 8'hA1)
        cmpsi_master_model_i.stop_cond();
        cmpsi_master_model_i.start_cond();
        cmpsi_master_model_i.write_byte(8'h32, a);
        cmpsi_master_model_i.write_byte(8'h45, a);
        cmpsi_master_model_i.start_cond();
        cmpsi_master_model_i.write_byte(8'h33, a);
        `CHECK(a, 1'b0)
        cmpsi_master_model_i.read_byte(1'b1, rb);
        `CHECK(rb, 8'hA0)
        cmpsi_master_model_i.stop_cond();
    endtask : t_read

    // New stored settings wait for the reset command
    task automatic t_reload();
        nv_addr = 8'h40;
        nv_opm = 8'h02;
        cmpsi_master_model_i.wait_q(20);
        `CHECK(edge_o, 1'b0)
        send('{8'h32, 8'h82, 8'h00, 8'h00, 8'h00}, 2);
        `CHECK(acks[1:0], 2'b00)
        `CHECK({edge_o, measure_en}, 2'b10)
        send('{8'h32, 8'h72, 8'h00, 8'h00, 8'h00}, 2);
        `CHECK(acks[0], 1'b1)
        send('{8'h40, 8'h72, 8'h00, 8'h00, 8'h00}, 2);
        `CHECK(acks[1:0], 2'b00)
        `CHECK(edge_o, 1'b0)
    endtask : t_reload

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // Hang guard well above the longest run
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        stop_test();
    end

    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
        `CHECK({edge_o, front_o, sda_oe}, 3'b000)
        `CHECK({analog_on, measure_en}, 2'b11)
        `CHECK({sda_out, resp_index}, 4'h0)
        t_orient();
        t_modes();
        t_args();
        t_nack_addr();
        t_read();
        t_reload();
        stop_test();
    end
endmodule : tb_cmpsi_slave
